// File: design/cefs_pkg.sv
// shared constants, register map and decode helpers of the CAN error and FIFO status block
package cefs_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_DEC_W = 8;
  localparam int unsigned FIFO_COUNT = 32;
  localparam int unsigned ERR_CNT_W = 8;
  localparam int unsigned TX_CNT_W = 9;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned EV_W = 5;

  // ****************************************
  // error state thresholds
  // ****************************************
  localparam logic [TX_CNT_W-1:0] BUS_OFF_LIMIT = 9'h100;
  localparam logic [TX_CNT_W-1:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [TX_CNT_W-1:0] WARN_LIMIT = 9'h060;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_DEC_W-1:0] OFF_ERROR_COUNT_STATE = 8'h00;
  localparam logic [ADDR_DEC_W-1:0] OFF_FIFO_PENDING_STATUS = 8'h04;
  localparam logic [ADDR_DEC_W-1:0] OFF_FIFO_OVERFLOW_STATUS = 8'h08;
  localparam logic [ADDR_DEC_W-1:0] OFF_SOURCE_CODE = 8'h0C;
  localparam logic [ADDR_DEC_W-1:0] OFF_EVENT_STATUS = 8'h10;
  localparam logic [ADDR_DEC_W-1:0] OFF_EVENT_MASK = 8'h14;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

  // ****************************************
  // field positions of error_count_state
  // ****************************************
  localparam int unsigned RX_CNT_LSB = 0;
  localparam int unsigned TX_CNT_LSB = 8;
  localparam int unsigned ANY_WARN_BIT = 16;
  localparam int unsigned RX_WARN_BIT = 17;
  localparam int unsigned TX_WARN_BIT = 18;
  localparam int unsigned RX_PASSIVE_BIT = 19;
  localparam int unsigned TX_PASSIVE_BIT = 20;
  localparam int unsigned TX_BUS_OFF_BIT = 21;

  // ****************************************
  // event status and mask bits
  // ****************************************
  localparam int unsigned EV_BUS_OFF = 0;
  localparam int unsigned EV_TX_PASSIVE = 1;
  localparam int unsigned EV_RX_PASSIVE = 2;
  localparam int unsigned EV_WARNING = 3;
  localparam int unsigned EV_RX_OVERFLOW = 4;

  localparam logic [CODE_W-1:0] CODE_NO_INTERRUPT = 7'h40;

  // ****************************************
  // bus encodings
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

  function automatic logic in_warn_band(input logic [TX_CNT_W-1:0] cnt);
    return (cnt >= WARN_LIMIT) && (cnt < PASSIVE_LIMIT);
  endfunction

  function automatic logic reg_hit(input logic [DATA_W-1:0] addr,
                                   input logic [ADDR_DEC_W-1:0] off);
    return addr[ADDR_DEC_W-1:0] == off;
  endfunction

endpackage

// File: design/cefs_err_state.sv
// error state decode from the transmit and receive error counts
`timescale 1ns/1ps
`default_nettype none
module cefs_err_state
  import cefs_pkg::*;
(
  // counts
  input wire logic [TX_CNT_W-1:0] tx_cnt,
  input wire logic [ERR_CNT_W-1:0] rx_cnt,
  // derived state
  output logic tx_bus_off_flag,
  output logic tx_error_passive_flag,
  output logic rx_error_passive_flag,
  output logic tx_warning_flag,
  output logic rx_warning_flag,
  output logic any_warning_flag
);
  assign tx_bus_off_flag = tx_cnt >= BUS_OFF_LIMIT;
  assign tx_error_passive_flag = tx_cnt >= PASSIVE_LIMIT;
  assign rx_error_passive_flag = {1'b0, rx_cnt} >= PASSIVE_LIMIT;
  assign tx_warning_flag = in_warn_band(tx_cnt);
  assign rx_warning_flag = in_warn_band({1'b0, rx_cnt});
  assign any_warning_flag = tx_warning_flag | rx_warning_flag;
endmodule // cefs_err_state
`default_nettype wire

// File: design/cefs_code_enc.sv
// lowest-numbered pending FIFO to interrupt source code
`timescale 1ns/1ps
`default_nettype none
module cefs_code_enc
  import cefs_pkg::*;
#(
  parameter int unsigned NUM_FIFO = FIFO_COUNT
)
(
  // pending vector
  input wire logic [NUM_FIFO-1:0] pending,
  // code
  output logic [CODE_W-1:0] interrupt_source_code
);
  // scan downward so the lowest FIFO number wins
  always_comb
  begin
    interrupt_source_code = CODE_NO_INTERRUPT;
    for (int i = NUM_FIFO - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        interrupt_source_code = CODE_W'(i);
      end
    end
  end
endmodule // cefs_code_enc
`default_nettype wire

// File: design/cefs_top.sv
// CAN error counter state, FIFO pending/overflow status and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - tx bus-off flag is high whenever the transmit error count is 256 or more.
// - tx error-passive flag is high whenever the transmit error count is 128 or more.
// - rx error-passive flag is high whenever the receive error count is 128 or more.
// - tx warning flag is high only while the transmit error count is from 96 to 127.
// - rx warning flag is high only while the receive error count is from 96 to 127.
// - the combined warning flag is the OR of the tx and rx warning flags.
// - the error count register shows the low eight bits of the tx count in bits 15:8 and rx count in bits 7:0.
// - bits 31:22 of the error count register read as zero.
// - each FIFO has a pending bit, set while an enabled interrupt of it is pending.
// - each FIFO has an overflow bit, set once that FIFO overflowed on reception.
// - every status field, count, pending and overflow bit is zero after reset; the source code resets to 0x40 (no interrupt).
// - the lowest-numbered FIFO n with a pending interrupt is reported as interrupt source code n.
// - a receive buffer overflow sets the module-level receive overflow flag.
module cefs_top
  import cefs_pkg::*;
#(
  parameter int unsigned NUM_FIFO = FIFO_COUNT
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [DATA_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [DATA_W-1:0] HWDATA,
  input wire logic HREADY,
  output logic [DATA_W-1:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // protocol engine side
  input wire logic [TX_CNT_W-1:0] TX_ERR_COUNT,
  input wire logic [ERR_CNT_W-1:0] RX_ERR_COUNT,
  input wire logic [NUM_FIFO-1:0] FIFO_IRQ_ACTIVE,
  input wire logic [NUM_FIFO-1:0] FIFO_OVF_EVENT,
  input wire logic [NUM_FIFO-1:0] FIFO_OVF_CLEAR,
  // status out
  output logic [CODE_W-1:0] INTERRUPT_SOURCE_CODE,
  output logic RX_BUFFER_OVERFLOW_FLAG,
  output logic IRQ
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [TX_CNT_W-1:0] tx_cnt;
    logic [ERR_CNT_W-1:0] rx_cnt;
    logic [NUM_FIFO-1:0] pending;
    logic [NUM_FIFO-1:0] overflow;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic prev_bus_off;
    logic prev_tx_passive;
    logic prev_rx_passive;
    logic prev_warning;
    logic [CODE_W-1:0] code;
    logic irq;
    logic wr_pend;
    logic [DATA_W-1:0] wr_addr;
    logic [DATA_W-1:0] rdata;
  } cefs_state_t;

  cefs_state_t st_ff;
  cefs_state_t nxt_st;
  logic rst_meta_ff;
  logic rst_sync_ff;

  logic tx_bus_off_flag;
  logic tx_error_passive_flag;
  logic rx_error_passive_flag;
  logic tx_warning_flag;
  logic rx_warning_flag;
  logic any_warning_flag;
  logic [CODE_W-1:0] interrupt_source_code;
  logic addr_phase;
  logic [DATA_W-1:0] err_word;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clear;

  // ****************************************
  // reset release
  // ****************************************
  // assert at once, release two clocks later so no flop sees a runt release
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // error state decode and code encoder
  // ****************************************
  cefs_err_state u_err_state (
    .tx_cnt(st_ff.tx_cnt),
    .rx_cnt(st_ff.rx_cnt),
    .tx_bus_off_flag(tx_bus_off_flag),
    .tx_error_passive_flag(tx_error_passive_flag),
    .rx_error_passive_flag(rx_error_passive_flag),
    .tx_warning_flag(tx_warning_flag),
    .rx_warning_flag(rx_warning_flag),
    .any_warning_flag(any_warning_flag)
  );

  cefs_code_enc #(
    .NUM_FIFO(NUM_FIFO)
  ) u_code_enc (
    .pending(st_ff.pending),
    .interrupt_source_code(interrupt_source_code)
  );

  // ****************************************
  // error count word
  // ****************************************
  always_comb
  begin
    err_word = REG_RESET;
    err_word[RX_CNT_LSB +: ERR_CNT_W] = st_ff.rx_cnt;
    // only the low eight bits are visible; bus-off tells software about 256
    err_word[TX_CNT_LSB +: ERR_CNT_W] = st_ff.tx_cnt[ERR_CNT_W-1:0];
    err_word[ANY_WARN_BIT] = any_warning_flag;
    err_word[RX_WARN_BIT] = rx_warning_flag;
    err_word[TX_WARN_BIT] = tx_warning_flag;
    err_word[RX_PASSIVE_BIT] = rx_error_passive_flag;
    err_word[TX_PASSIVE_BIT] = tx_error_passive_flag;
    err_word[TX_BUS_OFF_BIT] = tx_bus_off_flag;
  end

  // ****************************************
  // events
  // ****************************************
  always_comb
  begin
    ev_set = '0;
    ev_set[EV_BUS_OFF] = tx_bus_off_flag & ~st_ff.prev_bus_off;
    ev_set[EV_TX_PASSIVE] = tx_error_passive_flag & ~st_ff.prev_tx_passive;
    ev_set[EV_RX_PASSIVE] = rx_error_passive_flag & ~st_ff.prev_rx_passive;
    ev_set[EV_WARNING] = any_warning_flag & ~st_ff.prev_warning;
    ev_set[EV_RX_OVERFLOW] = |FIFO_OVF_EVENT;
    ev_clear = '0;
    if (st_ff.wr_pend && reg_hit(st_ff.wr_addr, OFF_EVENT_STATUS))
    begin
      ev_clear = HWDATA[EV_W-1:0];
    end
  end

  assign addr_phase = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    // counts are taken from the engine every clock
    nxt_st.tx_cnt = TX_ERR_COUNT;
    nxt_st.rx_cnt = RX_ERR_COUNT;
    nxt_st.pending = FIFO_IRQ_ACTIVE;
    // a new overflow in the clearing cycle is kept
    nxt_st.overflow = (st_ff.overflow & ~FIFO_OVF_CLEAR) | FIFO_OVF_EVENT;
    nxt_st.ev_status = (st_ff.ev_status & ~ev_clear) | ev_set;
    nxt_st.prev_bus_off = tx_bus_off_flag;
    nxt_st.prev_tx_passive = tx_error_passive_flag;
    nxt_st.prev_rx_passive = rx_error_passive_flag;
    nxt_st.prev_warning = any_warning_flag;
    nxt_st.code = interrupt_source_code;
    nxt_st.irq = |(nxt_st.ev_status & st_ff.ev_mask);
    if (st_ff.wr_pend && reg_hit(st_ff.wr_addr, OFF_EVENT_MASK))
    begin
      nxt_st.ev_mask = HWDATA[EV_W-1:0];
    end
    // address phase: remember writes, capture read data for the data phase
    nxt_st.wr_pend = addr_phase && HWRITE;
    nxt_st.wr_addr = HADDR;
    nxt_st.rdata = st_ff.rdata;
    if (addr_phase && !HWRITE)
    begin
      nxt_st.rdata = REG_RESET;
      if (reg_hit(HADDR, OFF_ERROR_COUNT_STATE))
      begin
        nxt_st.rdata = err_word;
      end
      else if (reg_hit(HADDR, OFF_FIFO_PENDING_STATUS))
      begin
        nxt_st.rdata = DATA_W'(st_ff.pending);
      end
      else if (reg_hit(HADDR, OFF_FIFO_OVERFLOW_STATUS))
      begin
        nxt_st.rdata = DATA_W'(st_ff.overflow);
      end
      else if (reg_hit(HADDR, OFF_SOURCE_CODE))
      begin
        nxt_st.rdata = DATA_W'(st_ff.code);
      end
      else if (reg_hit(HADDR, OFF_EVENT_STATUS))
      begin
        nxt_st.rdata = DATA_W'(st_ff.ev_status);
      end
      else if (reg_hit(HADDR, OFF_EVENT_MASK))
      begin
        nxt_st.rdata = DATA_W'(st_ff.ev_mask);
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      st_ff <= '0;
      st_ff.code <= CODE_NO_INTERRUPT;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // zero wait states: every register answers in the cycle after its address phase
  assign HREADYOUT = 1'b1;
  assign HRESP = HRESP_OKAY;
  assign HRDATA = st_ff.rdata;
  assign INTERRUPT_SOURCE_CODE = st_ff.code;
  assign RX_BUFFER_OVERFLOW_FLAG = st_ff.ev_status[EV_RX_OVERFLOW];
  assign IRQ = st_ff.irq;

endmodule // cefs_top
`default_nettype wire

// File: verif/cefs_top_sva.sv
// concurrent checks on the ports of the CAN error and FIFO status block
`timescale 1ns/1ps
`default_nettype none
module cefs_top_sva
  import cefs_pkg::*;
#(
  parameter int unsigned NUM_FIFO = FIFO_COUNT
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // bus
  input wire logic HSEL,
  input wire logic [DATA_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [DATA_W-1:0] HRDATA,
  // status side
  input wire logic [TX_CNT_W-1:0] TX_ERR_COUNT,
  input wire logic [ERR_CNT_W-1:0] RX_ERR_COUNT,
  input wire logic [NUM_FIFO-1:0] FIFO_IRQ_ACTIVE,
  input wire logic [NUM_FIFO-1:0] FIFO_OVF_EVENT,
  input wire logic [CODE_W-1:0] INTERRUPT_SOURCE_CODE,
  input wire logic RX_BUFFER_OVERFLOW_FLAG,
  input wire logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic rd_go;
  logic rd_err;
  logic rd_pend;
  assign rd_go = HSEL && HREADY && HTRANS[1] && !HWRITE;
  assign rd_err = rd_go && (HADDR[ADDR_DEC_W-1:0] == OFF_ERROR_COUNT_STATE);
  assign rd_pend = rd_go && (HADDR[ADDR_DEC_W-1:0] == OFF_FIFO_PENDING_STATUS);
  // read data shows the count registered two samples back
  chk_bus_off_bit:
    assert property (rd_err |=> HRDATA[21] == ($past(TX_ERR_COUNT, 2) >= BUS_OFF_LIMIT))
    else $error("bus-off bit wrong");
  chk_tx_passive_bit:
    assert property (rd_err |=> HRDATA[20] == ($past(TX_ERR_COUNT, 2) >= PASSIVE_LIMIT))
    else $error("tx passive bit wrong");
  chk_rx_passive_bit:
    assert property (rd_err |=> HRDATA[19] == ($past(RX_ERR_COUNT, 2) >= PASSIVE_LIMIT))
    else $error("rx passive bit wrong");
  chk_tx_warn_bit:
    assert property (rd_err |=> HRDATA[18] == ($past(TX_ERR_COUNT, 2) >= WARN_LIMIT &&
      $past(TX_ERR_COUNT, 2) < PASSIVE_LIMIT)) else $error("tx warning bit wrong");
  chk_rx_warn_bit:
    assert property (rd_err |=> HRDATA[17] == ($past(RX_ERR_COUNT, 2) >= WARN_LIMIT &&
      $past(RX_ERR_COUNT, 2) < PASSIVE_LIMIT)) else $error("rx warning bit wrong");
  chk_any_warn_bit:
    assert property (rd_err |=> HRDATA[16] == (HRDATA[17] || HRDATA[18]))
    else $error("combined warning bit wrong");
  chk_count_fields:
    assert property (rd_err |=> HRDATA[15:8] == 8'($past(TX_ERR_COUNT, 2)) &&
      HRDATA[7:0] == $past(RX_ERR_COUNT, 2) && HRDATA[31:22] == 10'h000)
    else $error("count fields wrong");
  chk_pending_copy:
    assert property (rd_pend |=> HRDATA[NUM_FIFO-1:0] == $past(FIFO_IRQ_ACTIVE, 2))
    else $error("pending bits wrong");
  chk_top_fifo_code:
    assert property ((FIFO_IRQ_ACTIVE[NUM_FIFO-1] && FIFO_IRQ_ACTIVE[NUM_FIFO-2:0] == '0) [*3]
      |-> INTERRUPT_SOURCE_CODE == CODE_W'(NUM_FIFO - 1)) else $error("fifo code wrong");
  chk_ovf_flag_set:
    assert property (|FIFO_OVF_EVENT |-> ##[1:2] RX_BUFFER_OVERFLOW_FLAG)
    else $error("overflow flag not set");
  cover property (rd_err ##1 HRDATA[21]);
  cover property (rd_err ##1 HRDATA[18]);
  cover property ($rose(IRQ));
endmodule // cefs_top_sva

bind cefs_top cefs_top_sva #(.NUM_FIFO(NUM_FIFO)) cefs_top_sva_inst (.CORE_CLK(CORE_CLK),
  .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .TX_ERR_COUNT(TX_ERR_COUNT),
  .RX_ERR_COUNT(RX_ERR_COUNT), .FIFO_IRQ_ACTIVE(FIFO_IRQ_ACTIVE),
  .FIFO_OVF_EVENT(FIFO_OVF_EVENT), .INTERRUPT_SOURCE_CODE(INTERRUPT_SOURCE_CODE),
  .RX_BUFFER_OVERFLOW_FLAG(RX_BUFFER_OVERFLOW_FLAG), .IRQ(IRQ));
`default_nettype wire

// File: verif/cefs_engine_model.sv
// behavioural protocol engine feeding counts and fifo events
`timescale 1ns/1ps
`default_nettype none
module cefs_engine_model
  import cefs_pkg::*;
(
  // clock
  input wire logic clk,
  // engine outputs
  output var logic [TX_CNT_W-1:0] tx_cnt,
  output var logic [ERR_CNT_W-1:0] rx_cnt,
  output var logic [FIFO_COUNT-1:0] irq_act,
  output var logic [FIFO_COUNT-1:0] ovf_ev,
  output var logic [FIFO_COUNT-1:0] ovf_clr
);
  initial
  begin
    tx_cnt = '0;
    rx_cnt = '0;
    irq_act = '0;
    ovf_ev = '0;
    ovf_clr = '0;
  end
  task automatic set_cnt(input logic [TX_CNT_W-1:0] t, input logic [ERR_CNT_W-1:0] r);
    @(posedge clk);
    tx_cnt <= t;
    rx_cnt <= r;
  endtask
  task automatic set_irq(input logic [FIFO_COUNT-1:0] v);
    @(posedge clk);
    irq_act <= v;
  endtask
  // events are single-cycle pulses, as the engine gives them
  task automatic pulse(input logic clr, input logic [FIFO_COUNT-1:0] v);
    @(posedge clk);
    if (clr) ovf_clr <= v; else ovf_ev <= v;
    @(posedge clk);
    ovf_clr <= '0;
    ovf_ev <= '0;
  endtask
endmodule // cefs_engine_model
`default_nettype wire

// File: verif/cefs_top_tb.sv
// self-checking bench of the CAN error and FIFO status block
`timescale 1ns/1ps
`default_nettype none
module cefs_top_tb;
  import cefs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [6:0] code;
  logic ovf_flag;
  logic irq;
  logic [8:0] tx_cnt;
  logic [7:0] rx_cnt;
  logic [31:0] irq_act;
  logic [31:0] ovf_ev;
  logic [31:0] ovf_clr;
  int n_fail = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  cefs_top cefs_top_inst (.CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .TX_ERR_COUNT(tx_cnt),
    .RX_ERR_COUNT(rx_cnt), .FIFO_IRQ_ACTIVE(irq_act), .FIFO_OVF_EVENT(ovf_ev),
    .FIFO_OVF_CLEAR(ovf_clr), .INTERRUPT_SOURCE_CODE(code),
    .RX_BUFFER_OVERFLOW_FLAG(ovf_flag), .IRQ(irq));
  cefs_engine_model cefs_engine_model_inst (.clk(clk), .tx_cnt(tx_cnt), .rx_cnt(rx_cnt),
    .irq_act(irq_act), .ovf_ev(ovf_ev), .ovf_clr(ovf_clr));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("BAD %s exp %h got %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    check(what, exp, d);
    // the slave never signals an error, so every data phase must end OKAY
    check("hresp", 32'(HRESP_OKAY), 32'(hresp));
  endtask
  function automatic logic [31:0] exp_err(input logic [8:0] t, input logic [7:0] r);
    logic tw;
    logic rw;
    tw = t >= 9'h060 && t < 9'h080;
    rw = r >= 8'h60 && r < 8'h80;
    return {10'h000, t >= 9'h100, t >= 9'h080, r >= 8'h80, tw, rw, tw | rw, t[7:0], r};
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd_chk("err reg", OFF_ERROR_COUNT_STATE, REG_RESET);
    rd_chk("pend reg", OFF_FIFO_PENDING_STATUS, REG_RESET);
    rd_chk("ovf reg", OFF_FIFO_OVERFLOW_STATUS, REG_RESET);
    rd_chk("code reg", OFF_SOURCE_CODE, 32'h0000_0040);
    rd_chk("event reg", OFF_EVENT_STATUS, REG_RESET);
    rd_chk("mask reg", OFF_EVENT_MASK, REG_RESET);
  endtask
  // band edges on both counts, bus-off wrap of the readable field
  task automatic t_err;
    logic [8:0] tv [8] = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h1FF, 9'h000};
    logic [7:0] rv [8] = '{8'h60, 8'h5F, 8'h80, 8'h7F, 8'h00, 8'h60, 8'hFF, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      cefs_engine_model_inst.set_cnt(tv[i], rv[i]);
      repeat (2) @(posedge clk);
      rd_chk("err reg", OFF_ERROR_COUNT_STATE, exp_err(tv[i], rv[i]));
    end
  endtask
  task automatic t_fifo;
    cefs_engine_model_inst.set_irq(32'h8000_0001);
    repeat (3) @(posedge clk);
    rd_chk("pend reg", OFF_FIFO_PENDING_STATUS, 32'h8000_0001);
    check("code", 32'h0000_0000, 32'(code));
    cefs_engine_model_inst.set_irq(32'h8000_0000);
    repeat (3) @(posedge clk);
    rd_chk("code reg", OFF_SOURCE_CODE, 32'h0000_001F);
    cefs_engine_model_inst.set_irq(32'h0000_0000);
  endtask
  task automatic t_ovf;
    cefs_engine_model_inst.pulse(1'b0, 32'h8000_0020);
    repeat (2) @(posedge clk);
    rd_chk("ovf reg", OFF_FIFO_OVERFLOW_STATUS, 32'h8000_0020);
    check("ovf flag", 32'h0000_0001, 32'(ovf_flag));
    wr(OFF_FIFO_OVERFLOW_STATUS, 32'h0000_0000);
    rd_chk("ovf reg", OFF_FIFO_OVERFLOW_STATUS, 32'h8000_0020);
    cefs_engine_model_inst.pulse(1'b1, 32'h0000_0020);
    repeat (2) @(posedge clk);
    rd_chk("ovf reg", OFF_FIFO_OVERFLOW_STATUS, 32'h8000_0000);
  endtask
  // mask gates the line; a one written to status clears it
  task automatic t_irq;
    rd_chk("event reg", OFF_EVENT_STATUS, 32'h0000_001F);
    check("irq", 32'h0000_0000, 32'(irq));
    wr(OFF_EVENT_MASK, 32'h0000_0010);
    repeat (2) @(posedge clk);
    check("irq", 32'h0000_0001, 32'(irq));
    wr(OFF_EVENT_STATUS, 32'h0000_001F);
    repeat (2) @(posedge clk);
    check("irq", 32'h0000_0000, 32'(irq));
    check("ovf flag", 32'h0000_0000, 32'(ovf_flag));
    rd_chk("mask reg", OFF_EVENT_MASK, 32'h0000_0010);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
  endtask
  task automatic results;
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_err;
    t_fifo;
    t_ovf;
    t_irq;
    // mid-run reset: sticky overflow bit and mask must both be gone
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    results;
  end
  initial
  begin
    #50000;
    n_fail++;
    results;
  end
endmodule // cefs_top_tb
`default_nettype wire
